/* sim/tap_ctrl_tb.sv */
// Self-checking bench for the test access port controller.
// Pins come from the master model; next states from a packed table.
`timescale 1ns/1ps
module tap_ctrl_tb;
	import tap_pkg::*;
	localparam logic [63:0] NXT0 = 64'h1bddbba146644311;
	localparam logic [63:0] NXT1 = 64'h2fefcc0287855920;
	localparam logic [11:0] IR_SEQ = 12'b010110000110;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic tck, tms, tdi, trst_n, test_reset_o, scan_en_o;
	logic [3:0] state_o, ir_o, st, eir, sr;
	int failures = 0;
	int samples_checked = 0;
	integer seed = 32'h392f;
	always #12.5 clk_i = ~clk_i;
	tap_host_model host(.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
		.trst_n_o(trst_n));
	tap_ctrl dut(.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .trst_n_i(trst_n), .ir_o(ir_o), .state_o(state_o),
		.test_reset_o(test_reset_o), .scan_en_o(scan_en_o));
	function automatic logic [3:0] nxt(input logic [3:0] s, input logic t);
		return t ? NXT1[{s, 2'b00} +: 4] : NXT0[{s, 2'b00} +: 4];
	endfunction
	// Latch timing inside update is open, so ir is skipped there
	task automatic check(input logic [3:0] es, input logic [3:0] ei);
		@(negedge clk_i);
		samples_checked++;
		if (state_o !== es || (ir_o !== ei && es != 4'hf)
			|| test_reset_o !== (es == 4'h0) || scan_en_o !== (es != 4'h0))
		begin
			$display("Error state/ir exp %h %h seen %h %h %b %b", es, ei, state_o, ir_o,
				test_reset_o, scan_en_o);
			failures++;
		end
	endtask
	task automatic go(input logic t, input logic d);
		host.step(t, d);
		if (st == 4'ha) sr = TAP_IR_CAPTURE;
		if (st == 4'hb) sr = {d, sr[3:1]};
		if (st == 4'hf) eir = sr;
		st = nxt(st, t);
		if (st == 4'h0) eir = TAP_IR_BYPASS;
		check(st, eir);
	endtask
	task automatic test_reset(input int waits);
		host.set_reset(1'b0);
		repeat (waits) @(posedge clk_i);
		st = 4'h0;
		eir = TAP_IR_BYPASS;
		check(st, eir);
		host.set_reset(1'b1);
		repeat (4) @(posedge clk_i);
		check(st, eir);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#600000;
		failures++;
		final_report();
	end
	initial
	begin
		st = 4'h0;
		eir = TAP_IR_BYPASS;
		sr = TAP_IR_BYPASS;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check(st, eir);
		test_reset(3);
		$display("test reset pin done");
		// Idle, into IR path, capture, three shifts, update, idle, then into DR capture
		for (int i = 0; i < 12; i++) go(IR_SEQ[i], 1'($random(seed)));
		$display("test ir load done");
		repeat (250) go(1'($random(seed)), 1'($random(seed)));
		repeat (5) go(1'b1, 1'($random(seed)));
		$display("test random walk done");
		go(1'b0, 1'b0);
		go(1'b1, 1'b0);
		go(1'b0, 1'b0);
		go(1'b0, 1'b0);
		test_reset(3);
		$display("test mid-shift reset done");
		final_report();
	end
endmodule

/* sim/tap_host_model.sv */
// Scan-chain master model driving the test pins.
// Assumes a 40 MHz caller clock: 5 low + 4 high cycles make 225 ns.
`timescale 1ns/1ps
module tap_host_model
(
	input wire logic clk_i, // Bench clock
	output logic tck_o, // Test clock, idles low
	output logic tms_o, // Mode select, starts high, then holds the last level from step or set_reset, which drives it high
	output logic tdi_o, // Test data
	output logic trst_n_o // Test reset, active low
);
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
		trst_n_o = 1'b1;
	end
	task automatic step(input logic tms, input logic tdi);
		@(posedge clk_i);
		tms_o <= tms;
		tdi_o <= tdi;
		repeat (4) @(posedge clk_i);
		tck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		tck_o <= 1'b0;
		tdi_o <= ~tdi; // Stale data never looks valid
	endtask
	task automatic set_reset(input logic lvl);
		@(posedge clk_i);
		tms_o <= 1'b1;
		trst_n_o <= lvl;
	endtask
endmodule

/* src/tap_ctrl.sv */
// Test access port controller with its reset behaviour.
// Samples the test clock, mode select and test reset with clk_i;
// the test clock must be well below half the system clock rate.
`timescale 1ns/1ps
module tap_ctrl
	import tap_pkg::*;
(
	input wire logic clk_i, // System clock, 40 MHz
	input wire logic rst_n_i, // Async reset, active low
	input wire logic tck_i, // Test clock pin
	input wire logic tms_i, // Mode select pin
	input wire logic tdi_i, // Test data in pin
	input wire logic trst_n_i, // Test reset pin, active low
	output logic [TAP_IR_W-1:0] ir_o, // Instruction register latches
	output logic [3:0] state_o, // Controller state
	output logic test_reset_o, // High in test-logic-reset
	output logic scan_en_o // Boundary scan enabled
);

	////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync_r;
	logic rst_n;
	tap_regs_t s_r;
	tap_regs_t s_nxt;
	logic tck_rise;
	logic trst_low;
	tap_state_t ns;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	assign tck_rise = s_r.tck_sync[1] & ~s_r.tck_prev;
	// Pin reset acts combinationally once synchronised, no tck edge needed
	assign trst_low = ~s_r.trst_sync[1];

	// Counter is three bits wide; refuse counts it cannot hold
	generate
		if (TAP_TMS_HIGH_CNT < 2 || TAP_TMS_HIGH_CNT > 7)
		begin : g_bad_cnt
			$error("tms high count does not fit the counter");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		ns = s_r.state;
		case (s_r.state)
			TAP_RESET: ns = s_r.tms_sync[1] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: ns = s_r.tms_sync[1] ? TAP_DR_SEL : TAP_IDLE;
			TAP_DR_SEL: ns = s_r.tms_sync[1] ? TAP_IR_SEL : TAP_DR_CAP;
			TAP_DR_CAP: ns = s_r.tms_sync[1] ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
			TAP_DR_SHIFT: ns = s_r.tms_sync[1] ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
			TAP_DR_EXIT1: ns = s_r.tms_sync[1] ? TAP_DR_UPD : TAP_DR_PAUSE;
			TAP_DR_PAUSE: ns = s_r.tms_sync[1] ? TAP_DR_EXIT2 : TAP_DR_PAUSE;
			TAP_DR_EXIT2: ns = s_r.tms_sync[1] ? TAP_DR_UPD : TAP_DR_SHIFT;
			TAP_DR_UPD: ns = s_r.tms_sync[1] ? TAP_DR_SEL : TAP_IDLE;
			TAP_IR_SEL: ns = s_r.tms_sync[1] ? TAP_RESET : TAP_IR_CAP;
			TAP_IR_CAP: ns = s_r.tms_sync[1] ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
			TAP_IR_SHIFT: ns = s_r.tms_sync[1] ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
			TAP_IR_EXIT1: ns = s_r.tms_sync[1] ? TAP_IR_UPD : TAP_IR_PAUSE;
			TAP_IR_PAUSE: ns = s_r.tms_sync[1] ? TAP_IR_EXIT2 : TAP_IR_PAUSE;
			TAP_IR_EXIT2: ns = s_r.tms_sync[1] ? TAP_IR_UPD : TAP_IR_SHIFT;
			TAP_IR_UPD: ns = s_r.tms_sync[1] ? TAP_DR_SEL : TAP_IDLE;
			default: ns = TAP_RESET;
		endcase
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tck_sync = {s_r.tck_sync[0], tck_i};
		s_nxt.tms_sync = {s_r.tms_sync[0], tms_i};
		s_nxt.trst_sync = {s_r.trst_sync[0], trst_n_i};
		// Data pin delayed like tck so the pair stays aligned
		s_nxt.tdi_sync = {s_r.tdi_sync[0], tdi_i};
		s_nxt.tck_prev = s_r.tck_sync[1];
		if (trst_low)
		begin
			s_nxt.state = TAP_RESET;
			s_nxt.tms_high_cnt = 3'h0;
		end
		else if (tck_rise)
		begin
			// Counter is a backstop; the state walk alone also reaches reset
			if (s_r.tms_sync[1])
			begin
				if (s_r.tms_high_cnt == 3'(TAP_TMS_HIGH_CNT - 1))
				begin
					s_nxt.state = TAP_RESET;
					s_nxt.tms_high_cnt = 3'h0;
				end
				else
				begin
					s_nxt.state = ns;
					s_nxt.tms_high_cnt = s_r.tms_high_cnt + 3'h1;
				end
			end
			else
			begin
				s_nxt.state = ns;
				s_nxt.tms_high_cnt = 3'h0;
			end
			if (s_r.state == TAP_IR_CAP)
				s_nxt.ir_shift = TAP_IR_CAPTURE;
			else if (s_r.state == TAP_IR_SHIFT)
				s_nxt.ir_shift = {s_r.tdi_sync[1], s_r.ir_shift[TAP_IR_W-1:1]};
			if (s_r.state == TAP_IR_UPD)
				s_nxt.ir_latch = s_r.ir_shift;
		end
		if (s_nxt.state == TAP_RESET)
		begin
			s_nxt.ir_shift = TAP_IR_BYPASS;
			s_nxt.ir_latch = TAP_IR_BYPASS;
		end
		s_nxt.in_reset = (s_nxt.state == TAP_RESET);
		s_nxt.scan_en = (s_nxt.state != TAP_RESET) && !trst_low;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.trst_sync <= 2'h0;
			s_r.tms_sync <= 2'h3;
			s_r.state <= TAP_RESET;
			s_r.ir_shift <= TAP_IR_BYPASS;
			s_r.ir_latch <= TAP_IR_BYPASS;
			s_r.in_reset <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign ir_o = s_r.ir_latch;
	assign state_o = s_r.state;
	assign test_reset_o = s_r.in_reset;
	assign scan_en_o = s_r.scan_en;

	////////////////////////////////////////////////////////////////
	AST_TRST_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
		!s_r.trst_sync[1] |=> s_r.state == TAP_RESET && !scan_en_o)
		else $error("test reset did not force reset state");

	AST_IR_BYPASS: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.state == TAP_RESET |-> ir_o == TAP_IR_BYPASS)
		else $error("instruction not bypass in reset");

	AST_SCAN_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
		test_reset_o |-> !scan_en_o)
		else $error("scan enabled in reset");

	AST_STAY_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.state == TAP_RESET && !(tck_rise && !s_r.tms_sync[1])
		|=> s_r.state == TAP_RESET)
		else $error("left reset without tms low edge");

	AST_FIVE_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.tms_high_cnt == 3'h4 && tck_rise && s_r.tms_sync[1]
		|=> s_r.state == TAP_RESET)
		else $error("five tms high did not reset");

	AST_NO_EDGE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
		!tck_rise && s_r.trst_sync[1] |=> $stable(s_r.state))
		else $error("state moved without test clock edge");

	AST_EXIT_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.state == TAP_RESET && tck_rise && !s_r.tms_sync[1] && s_r.trst_sync[1]
		|=> s_r.state == TAP_IDLE ##0 scan_en_o)
		else $error("reset did not go to idle");

	AST_IRSEL_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.state == TAP_IR_SEL && tck_rise && s_r.tms_sync[1]
		|=> test_reset_o)
		else $error("ir select with tms high did not reset");

	////////////////////////////////////////////////////////////////
	// Instruction path, reset flag and counter checks
	AST_TRST_IR: assert property (@(posedge clk_i) disable iff (!rst_n)
		!s_r.trst_sync[1]
		|=> ir_o == TAP_IR_BYPASS && test_reset_o)
		else $error("test reset did not load bypass");

	AST_OUT_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n)
		test_reset_o == (s_r.state == TAP_RESET))
		else $error("reset flag disagrees with state");

	AST_IR_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.trst_sync[1] && !tck_rise
		|=> $stable(ir_o))
		else $error("instruction moved without test clock edge");

	AST_UPD_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.trst_sync[1] && tck_rise && s_r.state == TAP_IR_UPD && !s_r.tms_sync[1]
		|=> ir_o == $past(s_r.ir_shift))
		else $error("update did not latch instruction");

	AST_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.trst_sync[1] && tck_rise && s_r.state == TAP_IR_CAP
		|=> s_r.ir_shift == TAP_IR_CAPTURE)
		else $error("capture value not loaded");

	AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.trst_sync[1] && tck_rise && s_r.state == TAP_IR_SHIFT
		|=> s_r.ir_shift[TAP_IR_W-1] == $past(s_r.tdi_sync[1]))
		else $error("shift did not take data bit");

	AST_CNT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.trst_sync[1] && tck_rise && !s_r.tms_sync[1]
		|=> s_r.tms_high_cnt == 3'h0)
		else $error("tms low did not clear counter");

	AST_CNT_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_r.tms_high_cnt < 3'(TAP_TMS_HIGH_CNT))
		else $error("tms high counter out of range");
endmodule

/* src/tap_pkg.sv */
// Constants and types for the test access port reset controller.
// Assumes one system clock; the test pins arrive asynchronously.
// Function
// - Low test reset forces reset, disables scan.
// - Reset state loads bypass into instruction register.
// - In reset, test logic idle, device normal.
// - Leave reset only after release plus sequence.
// - Five clocks with mode-select high force reset.
// - Mode-select sampled on test clock drives transitions.
package tap_pkg;
	localparam int TAP_IR_W = 4;
	localparam logic [TAP_IR_W-1:0] TAP_IR_BYPASS = 4'hf;
	localparam logic [TAP_IR_W-1:0] TAP_IR_CAPTURE = 4'h1;
	localparam int TAP_TMS_HIGH_CNT = 5;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_DR_SEL, TAP_DR_CAP, TAP_DR_SHIFT, TAP_DR_EXIT1,
		TAP_DR_PAUSE, TAP_DR_EXIT2, TAP_DR_UPD,
		TAP_IR_SEL, TAP_IR_CAP, TAP_IR_SHIFT, TAP_IR_EXIT1,
		TAP_IR_PAUSE, TAP_IR_EXIT2, TAP_IR_UPD
	} tap_state_t;

	typedef struct packed {
		logic [1:0] tck_sync;
		logic [1:0] tms_sync;
		logic [1:0] trst_sync;
		logic [1:0] tdi_sync;
		logic tck_prev;
		tap_state_t state;
		logic [TAP_IR_W-1:0] ir_shift;
		logic [TAP_IR_W-1:0] ir_latch;
		logic [2:0] tms_high_cnt;
		logic in_reset;
		logic scan_en;
	} tap_regs_t;
endpackage
